/* bench/io_space_register_decode_tb.sv */
// testbench: io decoder against an integer reference model
`timescale 1ns/1ps
module io_space_register_decode_tb;
  import iod_pkg::*;
  localparam iod_op_t PR = IOD_OP_PORT_READ;
  localparam iod_op_t PW = IOD_OP_PORT_WRITE;
  localparam iod_op_t DR = IOD_OP_DATA_READ;
  localparam iod_op_t DW = IOD_OP_DATA_WRITE;
  localparam iod_op_t BS = IOD_OP_BIT_SET;
  localparam iod_op_t BC = IOD_OP_BIT_CLEAR;
  localparam iod_op_t BT = IOD_OP_BIT_TEST;
  localparam int FA [7] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1C, 8'h2D, 8'h30};
  localparam int FW [7] = '{8'h07, 8'h27, 8'h07, 8'h27, 8'h07, 8'hC0, 8'h10};
  localparam int FM [7] = '{8'h07, 8'h27, 8'h07, 8'h27, 8'h07, 8'hC1, 8'hFF};
  localparam int RA [10] = '{8'h02, 8'h04, 8'h1E, 8'h2A, 8'h22, 8'h0C,
                             8'h31, 8'h21, 8'h1F, 8'h24};
  logic clk_sys_i;
  logic resetn_i;
  logic ce_i;
  iod_req_t req;
  iod_rsp_t rsp;
  logic [7:0] pins [4];
  logic [7:0] evt [7];
  logic ext_wr;
  logic ext_rd;
  logic [7:0] pa_out;
  logic [7:0] stb0;
  logic [7:0] stbp;
  iod_req_t hold_req;
  iod_rsp_t held;
  logic [7:0] rnd;
  int fails;
  int n_tests;
  int mdl [64];

  iod_decode dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req),
    .rsp_o(rsp), .port_a_pins_i(pins[0]), .port_b_pins_i(pins[1]),
    .port_c_pins_i(pins[2]), .port_d_pins_i(pins[3]),
    .timer0_evt_i(evt[0]), .timer1_evt_i(evt[1]), .timer2_evt_i(evt[2]),
    .timer3_evt_i(evt[3]), .ext_irq_evt_i(evt[4]), .serial_evt_i(evt[5]),
    .comparator_evt_i(evt[6]), .ext_wr_o(ext_wr), .ext_rd_o(ext_rd),
    .ext_addr_o(), .ext_wdata_o(), .ext_rdata_i(8'h00),
    .port_a_dir_o(), .port_a_out_o(pa_out), .port_b_dir_o(),
    .port_b_out_o(), .port_c_dir_o(), .port_c_out_o(), .port_d_dir_o(),
    .port_d_out_o(), .ext_irq_mask_o(), .eeprom_control_o(),
    .eeprom_data_o(), .eeprom_addr_o(), .timer0_control_a_o(),
    .timer0_control_b_o(), .timer0_count_o(), .timer0_compare_a_o(),
    .timer0_compare_b_o(), .prescaler_sync_o(), .serial_control_o(),
    .serial_data_o(), .comparator_o(), .debug_data_o(),
    .strobe_timer0_o(stb0), .strobe_prescaler_o(stbp)
  );
  iod_core_model core (.clk_sys_i(clk_sys_i), .req_o(req), .rsp_i(rsp));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // w selects the clear-on-one bits, else the writable bits
  function automatic int msk(int a, bit w);
    foreach (FA[i]) if (FA[i] == a) return w ? FW[i] : FM[i];
    if (w || (a > 8'h0B && a < 8'h15) || a == 8'h29 || a == 8'h2F)
      return 0;
    case (a)
      8'h1F: return 8'h3F;
      8'h22: return 8'h0F;
      8'h23: return 8'h80;
      8'h24: return 8'hF3;
      8'h25: return 8'h0F;
      default: return 8'hFF;
    endcase
  endfunction
  function automatic int rd(int a);
    return (a < 10 && a % 3 == 0) ? pins[a / 3] : mdl[a];
  endfunction
  task automatic wr(int a, int d);
    if (!(a < 10 && a % 3 == 0))
      mdl[a] = (mdl[a] & ~d & msk(a, 1)) | (d & msk(a, 0) & ~msk(a, 1));
  endtask
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // e holds rdata, bit value, extended select, refused
  task automatic xfer(iod_op_t op, int a, int b, int d, bit rude);
    iod_req_t r;
    iod_rsp_t got;
    logic [10:0] e;
    int io;
    e = '0;
    io = a;
    if (op == DR || op == DW) begin
      io = (a < 8'h20 || a > 8'h5F) ? -1 : a - 8'h20;
      e[1] = a > 8'h5F;
    end else if ((op == PR || op == PW) ? a > 8'h3F : a > 8'h1F) begin
      io = -1;
      e[0] = 1'b1;
    end
    if (io >= 0) begin
      if (op == PR || op == DR)
        e[10:3] = 8'(rd(io));
      if (op == PW || op == DW)
        wr(io, d);
      if (op == BT)
        e[2] = 1'(rd(io) >> b);
      if (op == BS)
        wr(io, rd(io) | (1 << b));
      if (op == BC)
        wr(io, rd(io) & ~(1 << b));
    end
    r = '{op, 8'(a), 3'(b), 8'(d)};
    core.issue(r, rude, got);
    check(16'(got), 16'(e));
    check(16'({ext_wr, ext_rd}), {14'h0, op == DW && e[1], op == DR && e[1]});
    check(16'(pa_out), 16'(mdl[2]));
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clk_sys_i);
    fails++;
    end_of_test();
  end

  initial begin
    ce_i = 1'b1;
    resetn_i = 1'b0;
    rnd = 8'h04;
    fails = 0;
    n_tests = 0;
    foreach (pins[i]) pins[i] = 8'h00;
    foreach (evt[i]) evt[i] = 8'h00;
    foreach (mdl[i]) mdl[i] = 0;
    repeat (16) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    foreach (RA[i]) begin
      xfer(PR, RA[i], 0, 0, 0);
      rnd = lfsr(rnd);
      xfer(PW, RA[i], 0, rnd, 1);
      xfer(DR, RA[i] + 8'h20, 0, 0, 0);
      rnd = lfsr(rnd);
      xfer(DW, RA[i] + 8'h20, 0, rnd & msk(RA[i], 0), 0);
      xfer(PR, RA[i], 0, 0, 0);
    end
    for (int p = 0; p < 4; p++) begin
      rnd = lfsr(rnd);
      pins[p] = rnd;
      xfer(PW, 3 * p, 0, ~rnd, 1);
      xfer(PR, 3 * p, 0, 0, 0);
      xfer(BT, 3 * p, p, 0, 0);
    end
    for (int b = 0; b < 8; b++) begin
      xfer(BS, 2, b, 0, 0);
      xfer(BT, 2, b, 0, 0);
      xfer(BC, 2, (b + 3) % 8, 0, 0);
      xfer(BS, 8'h20 + b, b, 0, 0);
    end
    foreach (FA[i]) begin
      core.idle();
      evt[i] = 8'hFF;
      @(negedge clk_sys_i);
      evt[i] = 8'h00;
      mdl[FA[i]] = mdl[FA[i]] | FW[i];
      xfer(PR, FA[i], 0, 0, 0);
      rnd = lfsr(rnd);
      xfer(PW, FA[i], 0, rnd, 1);
      xfer(PR, FA[i], 0, 0, 0);
      xfer(BS, FA[i], 3, 0, 0);
      xfer(PR, FA[i], 0, 0, 0);
    end
    xfer(PW, 8'h25, 0, 8'hFF, 0);
    check(16'(stb0), 16'(STROBE_TIMER0_CONTROL_B));
    xfer(DW, 8'h43, 0, 8'hFF, 0);
    check(16'({stb0, stbp}), {8'h00, STROBE_PRESCALER_SYNC});
    xfer(PR, 8'h25, 0, 0, 0);
    xfer(DR, 8'h43, 0, 0, 0);
    xfer(DW, 8'h80, 0, 8'h11, 0);
    xfer(DR, 8'hFF, 0, 0, 0);
    xfer(DR, 8'h10, 0, 0, 0);
    xfer(PR, 8'h40, 0, 0, 0);
    // clock enable low: write is dropped and the refused answer stays
    ce_i = 1'b0;
    hold_req = '{PW, 8'h02, 3'h0, 8'h5A};
    core.issue(hold_req, 0, held);
    check(16'(pa_out), 16'(mdl[2]));
    check(16'(held), 16'h0001);
    ce_i = 1'b1;
    core.idle();
    repeat (2) @(negedge clk_sys_i);
    end_of_test();
  end
endmodule // io_space_register_decode_tb

bind iod_decode iod_decode_sva chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req_i),
  .rsp_o(rsp_o), .ext_wr_o(ext_wr_o), .ext_rd_o(ext_rd_o),
  .ext_addr_o(ext_addr_o), .port_a_out_o(port_a_out_o)
);

/* bench/iod_core_model.sv */
// core model: issues one io request per cycle
`timescale 1ns/1ps
module iod_core_model
  import iod_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // request out, answer in
  output iod_req_t req_o,
  input wire iod_rsp_t rsp_i
);
  initial req_o = '0;
  function automatic bit rsvd(logic [7:0] a);
    return (a > 8'h0B && a < 8'h15) || a == 8'h29 || a == 8'h2F;
  endfunction
  task automatic idle();
    req_o = '0;
  endtask
  // entered at a falling edge, answer taken at the next one
  task automatic issue(input iod_req_t r, input bit rude,
                       output iod_rsp_t a);
    iod_req_t q;
    q = r;
    if (!rude && ((q.op == IOD_OP_PORT_WRITE && rsvd(q.addr)) ||
        (q.op == IOD_OP_DATA_WRITE && rsvd(q.addr - 8'h20))))
      q.op = IOD_OP_NONE;
    req_o = q;
    @(negedge clk_sys_i);
    a = rsp_i;
  endtask
endmodule // iod_core_model

/* bench/iod_decode_sva.sv */
// checker: mapping and timing properties of the io decoder
`timescale 1ns/1ps
module iod_decode_sva
  import iod_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire iod_req_t req_i,
  input wire iod_rsp_t rsp_o,
  input wire logic ext_wr_o,
  input wire logic ext_rd_o,
  input wire logic [7:0] ext_addr_o,
  input wire logic [7:0] port_a_out_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take(iod_op_t o, logic [7:0] a);
    ce_i && req_i.op == o && req_i.addr == a;
  endsequence
  sequence s_port;
    ce_i && req_i.op inside {IOD_OP_PORT_READ, IOD_OP_PORT_WRITE};
  endsequence
  a_port_refused: assert property (
    s_port ##0 req_i.addr > 8'h3F |=> rsp_o.refused)
    else $error("port op above 0x3F not refused");
  a_port_no_ext: assert property (
    s_port |=> !ext_wr_o && !ext_rd_o && !rsp_o.ext_sel)
    else $error("port op reached extended region");
  a_bit_refused: assert property (
    ce_i && req_i.op inside {IOD_OP_BIT_SET, IOD_OP_BIT_CLEAR,
    IOD_OP_BIT_TEST} && req_i.addr > 8'h1F |=> rsp_o.refused)
    else $error("bit op above 0x1F not refused");
  a_ext_write: assert property (
    ce_i && req_i.op == IOD_OP_DATA_WRITE && req_i.addr > 8'h5F |=>
    ext_wr_o && rsp_o.ext_sel && ext_addr_o == $past(req_i.addr))
    else $error("extended write not passed out");
  a_port_a_write: assert property (
    s_take(IOD_OP_PORT_WRITE, 8'h02) |=>
    port_a_out_o == $past(req_i.wdata))
    else $error("port write to 0x02 lost");
  a_data_a_write: assert property (
    s_take(IOD_OP_DATA_WRITE, 8'h22) |=>
    port_a_out_o == $past(req_i.wdata))
    else $error("data write to 0x22 lost");
  a_bit_test: assert property (
    s_take(IOD_OP_BIT_TEST, 8'h02) |=>
    rsp_o.bit_val == $past(port_a_out_o[req_i.bit_sel]))
    else $error("bit test result wrong");
  a_bit_set: assert property (
    s_take(IOD_OP_BIT_SET, 8'h02) |=> port_a_out_o ==
    ($past(port_a_out_o) | (8'h01 << $past(req_i.bit_sel))))
    else $error("bit set result wrong");
  a_idle_quiet: assert property (
    ce_i && req_i.op == IOD_OP_NONE |=> rsp_o == '0 && !ext_wr_o)
    else $error("answer without request");
endmodule // iod_decode_sva

/* src/iod_byte_reg.sv */
// one 8-bit register with reserved-bit masking and write-one-to-clear flags
`timescale 1ns/1ps
module iod_byte_reg
  import iod_pkg::*;
#(
  parameter logic [7:0] WMASK = M_FULL,
  parameter logic [7:0] W1C = ZERO_BYTE,
  parameter logic [7:0] STROBE = ZERO_BYTE
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // access side
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // hardware flag events
  input wire logic [7:0] hw_set_i,
  // state
  output logic [7:0] value_o,
  output logic [7:0] strobe_o
);
  logic [7:0] next_value;

  always_comb begin
    next_value = value_o;
    if (wr_i) begin
      // plain bits take data, flag bits clear on one, reserved untouched
      next_value = (value_o & ~WMASK) | (wdata_i & WMASK & ~W1C & ~STROBE) |
        (value_o & W1C & ~wdata_i);
    end
    next_value = (next_value | (hw_set_i & W1C)) & ~STROBE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      value_o <= RESET_VALUE;
    end else if (ce_i) begin
      value_o <= next_value & WMASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      strobe_o <= RESET_VALUE;
    end else if (ce_i) begin
      strobe_o <= wr_i ? (wdata_i & STROBE) : RESET_VALUE;
    end
  end
endmodule // iod_byte_reg

/* src/iod_decode.sv */
// io space decoder and register bank for the processor core
`timescale 1ns/1ps
module iod_decode
  import iod_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // core request and answer
  input wire iod_req_t req_i,
  output iod_rsp_t rsp_o,
  // pin levels from the port pads
  input wire logic [7:0] port_a_pins_i,
  input wire logic [7:0] port_b_pins_i,
  input wire logic [7:0] port_c_pins_i,
  input wire logic [7:0] port_d_pins_i,
  // flag events from peripherals, one per bit
  input wire logic [7:0] timer0_evt_i,
  input wire logic [7:0] timer1_evt_i,
  input wire logic [7:0] timer2_evt_i,
  input wire logic [7:0] timer3_evt_i,
  input wire logic [7:0] ext_irq_evt_i,
  input wire logic [7:0] serial_evt_i,
  input wire logic [7:0] comparator_evt_i,
  // extended region access handed to outside logic
  output logic ext_wr_o,
  output logic ext_rd_o,
  output logic [7:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  input wire logic [7:0] ext_rdata_i,
  // register contents to peripherals
  output logic [7:0] port_a_dir_o,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_b_dir_o,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_c_dir_o,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_d_dir_o,
  output logic [7:0] port_d_out_o,
  output logic [7:0] ext_irq_mask_o,
  output logic [7:0] eeprom_control_o,
  output logic [7:0] eeprom_data_o,
  output logic [15:0] eeprom_addr_o,
  output logic [7:0] timer0_control_a_o,
  output logic [7:0] timer0_control_b_o,
  output logic [7:0] timer0_count_o,
  output logic [7:0] timer0_compare_a_o,
  output logic [7:0] timer0_compare_b_o,
  output logic [7:0] prescaler_sync_o,
  output logic [7:0] serial_control_o,
  output logic [7:0] serial_data_o,
  output logic [7:0] comparator_o,
  output logic [7:0] debug_data_o,
  output logic [7:0] strobe_timer0_o,
  output logic [7:0] strobe_prescaler_o
);
  localparam int unsigned NREG = 37;
  localparam int unsigned IO_SPAN = 64;

  // per-slot descriptors indexed by io address
  typedef struct packed {
    logic present;
    logic writable;
    logic [7:0] wmask;
    logic [7:0] w1c;
    logic [7:0] strobe;
  } iod_slot_t;

  function automatic iod_slot_t slot_of(input logic [5:0] a);
    iod_slot_t s;
    s = '{present: 1'b1, writable: 1'b1, wmask: M_FULL, w1c: ZERO_BYTE,
      strobe: ZERO_BYTE};
    case (a)
      A_PORT_A_PIN_INPUT, A_PORT_B_PIN_INPUT, A_PORT_C_PIN_INPUT,
      A_PORT_D_PIN_INPUT: s.writable = 1'b0;
      A_PORT_A_DIRECTION, A_PORT_A_OUTPUT, A_PORT_B_DIRECTION,
      A_PORT_B_OUTPUT, A_PORT_C_DIRECTION, A_PORT_C_OUTPUT,
      A_PORT_D_DIRECTION, A_PORT_D_OUTPUT, A_EXTERNAL_IRQ_MASK,
      A_GENERAL_SCRATCH_0, A_EEPROM_DATA, A_EEPROM_ADDRESS_LOW,
      A_TIMER0_COUNT, A_TIMER0_COMPARE_A, A_TIMER0_COMPARE_B,
      A_GENERAL_SCRATCH_1, A_GENERAL_SCRATCH_2, A_SERIAL_PERIPH_CONTROL,
      A_SERIAL_PERIPH_DATA, A_DEBUG_DATA: s.wmask = M_FULL;
      A_TIMER0_FLAGS, A_TIMER2_FLAGS: begin
        s.wmask = M_TIMER_FLAGS;
        s.w1c = M_TIMER_FLAGS;
      end
      A_TIMER1_FLAGS, A_TIMER3_FLAGS: begin
        s.wmask = M_TIMER_FLAGS_CAP;
        s.w1c = M_TIMER_FLAGS_CAP;
      end
      A_EXTERNAL_IRQ_FLAGS: begin
        s.wmask = M_EXT_IRQ;
        s.w1c = M_EXT_IRQ;
      end
      A_EEPROM_CONTROL: begin
        s.wmask = M_EEPROM_CONTROL;
        s.w1c = W1C_EEPROM_CONTROL;
      end
      A_EEPROM_ADDRESS_HIGH: s.wmask = M_EEPROM_ADDR_HIGH;
      A_TIMER_PRESCALER_SYNC: begin
        s.wmask = M_PRESCALER_SYNC;
        s.strobe = STROBE_PRESCALER_SYNC;
      end
      A_TIMER0_CONTROL_A: s.wmask = M_TIMER0_CONTROL_A;
      A_TIMER0_CONTROL_B: begin
        s.wmask = M_TIMER0_CONTROL_B;
        s.strobe = STROBE_TIMER0_CONTROL_B;
      end
      A_SERIAL_PERIPH_STATUS: begin
        s.wmask = M_SERIAL_STATUS;
        s.w1c = W1C_SERIAL_STATUS;
      end
      A_COMPARATOR_CTRL_STAT: s.w1c = W1C_COMPARATOR;
      default: begin
        s.present = 1'b0;
        s.writable = 1'b0;
        s.wmask = ZERO_BYTE;
      end
    endcase
    return s;
  endfunction

  // address decode of the request
  logic is_port_op;
  logic is_data_op;
  logic is_bit_op;
  logic data_in_io;
  logic data_in_ext;
  logic [5:0] io_addr;
  logic hit_io;
  logic do_read;
  logic do_write;
  logic [7:0] write_byte;
  logic [7:0] cur_byte;
  logic [7:0] bit_mask;
  logic refuse;
  iod_slot_t cur_slot;
  logic [7:0] reg_val [IO_SPAN];
  logic [7:0] strobe_val [IO_SPAN];
  logic [7:0] pin_val [IO_SPAN];
  logic [7:0] evt_val [IO_SPAN];
  logic [7:0] data_addr;

  assign data_addr = req_i.addr - DATA_IO_OFFSET;

  always_comb begin
    is_port_op = (req_i.op == IOD_OP_PORT_READ) ||
      (req_i.op == IOD_OP_PORT_WRITE);
    is_data_op = (req_i.op == IOD_OP_DATA_READ) ||
      (req_i.op == IOD_OP_DATA_WRITE);
    is_bit_op = (req_i.op == IOD_OP_BIT_SET) ||
      (req_i.op == IOD_OP_BIT_CLEAR) || (req_i.op == IOD_OP_BIT_TEST);
    data_in_io = (req_i.addr >= DATA_IO_OFFSET) &&
      (req_i.addr < DATA_EXT_LO);
    data_in_ext = req_i.addr >= DATA_EXT_LO;
    io_addr = is_data_op ? data_addr[IO_AW-1:0] :
      req_i.addr[IO_AW-1:0];
    refuse = 1'b0;
    if (is_port_op && (req_i.addr[DATA_AW-1:IO_AW] != 2'b00)) begin
      refuse = 1'b1;
    end
    if (is_bit_op && (req_i.addr > {2'b00, BIT_IO_LAST})) begin
      refuse = 1'b1;
    end
    hit_io = !refuse && (is_port_op || is_bit_op ||
      (is_data_op && data_in_io));
    cur_slot = slot_of(io_addr);
    cur_byte = reg_val[io_addr];
    bit_mask = 8'h01 << req_i.bit_sel;
    do_read = hit_io && ((req_i.op == IOD_OP_PORT_READ) ||
      (req_i.op == IOD_OP_DATA_READ));
    do_write = hit_io && cur_slot.writable &&
      (req_i.op != IOD_OP_PORT_READ) && (req_i.op != IOD_OP_DATA_READ) &&
      (req_i.op != IOD_OP_BIT_TEST);
    // bit ops rewrite the byte as read, so set flags go back as ones
    case (req_i.op)
      IOD_OP_BIT_SET: write_byte = cur_byte | bit_mask;
      IOD_OP_BIT_CLEAR: write_byte = cur_byte & ~bit_mask;
      default: write_byte = req_i.wdata;
    endcase
  end

  // register slots, one per io address
  genvar g;
  generate
    for (g = 0; g < IO_SPAN; g++) begin : g_slot
      localparam iod_slot_t S = slot_of(6'(g));
      if (S.present && S.writable) begin : g_reg
        iod_byte_reg #(
          .WMASK(S.wmask),
          .W1C(S.w1c),
          .STROBE(S.strobe)
        ) u_reg (
          .clk_sys_i(clk_sys_i),
          .resetn_i(resetn_i),
          .ce_i(ce_i),
          .wr_i(do_write && (io_addr == 6'(g))),
          .wdata_i(write_byte),
          .hw_set_i(evt_val[g]),
          .value_o(reg_val[g]),
          .strobe_o(strobe_val[g])
        );
      end else begin : g_fixed
        assign reg_val[g] = pin_val[g];
        assign strobe_val[g] = ZERO_BYTE;
      end
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < IO_SPAN; i++) begin
      pin_val[i] = ZERO_BYTE;
      evt_val[i] = ZERO_BYTE;
    end
    pin_val[A_PORT_A_PIN_INPUT] = port_a_pins_i;
    pin_val[A_PORT_B_PIN_INPUT] = port_b_pins_i;
    pin_val[A_PORT_C_PIN_INPUT] = port_c_pins_i;
    pin_val[A_PORT_D_PIN_INPUT] = port_d_pins_i;
    evt_val[A_TIMER0_FLAGS] = timer0_evt_i;
    evt_val[A_TIMER1_FLAGS] = timer1_evt_i;
    evt_val[A_TIMER2_FLAGS] = timer2_evt_i;
    evt_val[A_TIMER3_FLAGS] = timer3_evt_i;
    evt_val[A_EXTERNAL_IRQ_FLAGS] = ext_irq_evt_i;
    evt_val[A_SERIAL_PERIPH_STATUS] = serial_evt_i;
    evt_val[A_COMPARATOR_CTRL_STAT] = comparator_evt_i;
  end

  // answer registered one cycle after the request
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rsp_o <= '0;
    end else if (ce_i) begin
      rsp_o.rdata <= do_read ? cur_byte : ZERO_BYTE;
      rsp_o.bit_val <= (req_i.op == IOD_OP_BIT_TEST) && hit_io &&
        |(cur_byte & bit_mask);
      rsp_o.ext_sel <= is_data_op && data_in_ext;
      rsp_o.refused <= refuse;
    end
  end

  // extended region strobes fire only for data-space ops; address and data follow every request
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ext_wr_o <= 1'b0;
      ext_rd_o <= 1'b0;
      ext_addr_o <= ZERO_BYTE;
      ext_wdata_o <= ZERO_BYTE;
    end else if (ce_i) begin
      ext_wr_o <= (req_i.op == IOD_OP_DATA_WRITE) && data_in_ext;
      ext_rd_o <= (req_i.op == IOD_OP_DATA_READ) && data_in_ext;
      ext_addr_o <= req_i.addr;
      ext_wdata_o <= req_i.wdata;
    end
  end

  logic [7:0] unused_ext_rdata;
  assign unused_ext_rdata = ext_rdata_i;

  assign port_a_dir_o = reg_val[A_PORT_A_DIRECTION];
  assign port_a_out_o = reg_val[A_PORT_A_OUTPUT];
  assign port_b_dir_o = reg_val[A_PORT_B_DIRECTION];
  assign port_b_out_o = reg_val[A_PORT_B_OUTPUT];
  assign port_c_dir_o = reg_val[A_PORT_C_DIRECTION];
  assign port_c_out_o = reg_val[A_PORT_C_OUTPUT];
  assign port_d_dir_o = reg_val[A_PORT_D_DIRECTION];
  assign port_d_out_o = reg_val[A_PORT_D_OUTPUT];
  assign ext_irq_mask_o = reg_val[A_EXTERNAL_IRQ_MASK];
  assign eeprom_control_o = reg_val[A_EEPROM_CONTROL];
  assign eeprom_data_o = reg_val[A_EEPROM_DATA];
  assign eeprom_addr_o = {reg_val[A_EEPROM_ADDRESS_HIGH],
    reg_val[A_EEPROM_ADDRESS_LOW]};
  assign timer0_control_a_o = reg_val[A_TIMER0_CONTROL_A];
  assign timer0_control_b_o = reg_val[A_TIMER0_CONTROL_B];
  assign timer0_count_o = reg_val[A_TIMER0_COUNT];
  assign timer0_compare_a_o = reg_val[A_TIMER0_COMPARE_A];
  assign timer0_compare_b_o = reg_val[A_TIMER0_COMPARE_B];
  assign prescaler_sync_o = reg_val[A_TIMER_PRESCALER_SYNC];
  assign serial_control_o = reg_val[A_SERIAL_PERIPH_CONTROL];
  assign serial_data_o = reg_val[A_SERIAL_PERIPH_DATA];
  assign comparator_o = reg_val[A_COMPARATOR_CTRL_STAT];
  assign debug_data_o = reg_val[A_DEBUG_DATA];
  assign strobe_timer0_o = strobe_val[A_TIMER0_CONTROL_B];
  assign strobe_prescaler_o = strobe_val[A_TIMER_PRESCALER_SYNC];
endmodule // iod_decode

/* src/iod_pkg.sv */
// package: io space decode constants, register map, request/answer structs
package iod_pkg;
  localparam int unsigned IO_AW = 6;
  localparam int unsigned DATA_AW = 8;
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0] DATA_EXT_LO = 8'h60;
  localparam logic [5:0] BIT_IO_LAST = 6'h1F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // register offsets in io space
  localparam logic [5:0] A_PORT_A_PIN_INPUT = 6'h00;
  localparam logic [5:0] A_PORT_A_DIRECTION = 6'h01;
  localparam logic [5:0] A_PORT_A_OUTPUT = 6'h02;
  localparam logic [5:0] A_PORT_B_PIN_INPUT = 6'h03;
  localparam logic [5:0] A_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] A_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] A_PORT_C_PIN_INPUT = 6'h06;
  localparam logic [5:0] A_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] A_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] A_PORT_D_PIN_INPUT = 6'h09;
  localparam logic [5:0] A_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] A_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] A_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] A_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] A_TIMER2_FLAGS = 6'h17;
  localparam logic [5:0] A_TIMER3_FLAGS = 6'h18;
  localparam logic [5:0] A_EXTERNAL_IRQ_FLAGS = 6'h1C;
  localparam logic [5:0] A_EXTERNAL_IRQ_MASK = 6'h1D;
  localparam logic [5:0] A_GENERAL_SCRATCH_0 = 6'h1E;
  localparam logic [5:0] A_EEPROM_CONTROL = 6'h1F;
  localparam logic [5:0] A_EEPROM_DATA = 6'h20;
  localparam logic [5:0] A_EEPROM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] A_EEPROM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] A_TIMER_PRESCALER_SYNC = 6'h23;
  localparam logic [5:0] A_TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] A_TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] A_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] A_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] A_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] A_GENERAL_SCRATCH_1 = 6'h2A;
  localparam logic [5:0] A_GENERAL_SCRATCH_2 = 6'h2B;
  localparam logic [5:0] A_SERIAL_PERIPH_CONTROL = 6'h2C;
  localparam logic [5:0] A_SERIAL_PERIPH_STATUS = 6'h2D;
  localparam logic [5:0] A_SERIAL_PERIPH_DATA = 6'h2E;
  localparam logic [5:0] A_COMPARATOR_CTRL_STAT = 6'h30;
  localparam logic [5:0] A_DEBUG_DATA = 6'h31;

  // writable-bit masks; unlisted bits are reserved
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] M_TIMER_FLAGS_CAP = 8'h27;
  localparam logic [7:0] M_TIMER_FLAGS = 8'h07;
  localparam logic [7:0] M_EXT_IRQ = 8'h07;
  localparam logic [7:0] M_EEPROM_CONTROL = 8'h3F;
  localparam logic [7:0] M_EEPROM_ADDR_HIGH = 8'h0F;
  localparam logic [7:0] M_PRESCALER_SYNC = 8'h83;
  localparam logic [7:0] M_TIMER0_CONTROL_A = 8'hF3;
  localparam logic [7:0] M_TIMER0_CONTROL_B = 8'hCF;
  localparam logic [7:0] M_SERIAL_STATUS = 8'hC1;
  // write-one-to-clear flag bits inside mixed registers
  localparam logic [7:0] W1C_SERIAL_STATUS = 8'hC0;
  localparam logic [7:0] W1C_COMPARATOR = 8'h10;
  localparam logic [7:0] W1C_EEPROM_CONTROL = 8'h00;
  // strobe-only bits that always read as zero
  localparam logic [7:0] STROBE_TIMER0_CONTROL_B = 8'hC0;
  localparam logic [7:0] STROBE_PRESCALER_SYNC = 8'h03;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  typedef enum logic [2:0] {
    IOD_OP_NONE,
    IOD_OP_PORT_READ,
    IOD_OP_PORT_WRITE,
    IOD_OP_DATA_READ,
    IOD_OP_DATA_WRITE,
    IOD_OP_BIT_SET,
    IOD_OP_BIT_CLEAR,
    IOD_OP_BIT_TEST
  } iod_op_t;

  typedef struct packed {
    iod_op_t op;
    logic [DATA_AW-1:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iod_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic bit_val;
    logic ext_sel;
    logic refused;
  } iod_rsp_t;
endpackage
